// *** hdl/hpm_buf2.sv ***
`timescale 1ns/1ps
module hpm_buf2
    import hpm_pkg::*;
#(
    parameter int W     = STREAM_W,
    parameter int DEPTH = BUF_DEPTH
) (
    // Clock and reset.
    input wire logic   mclk,
    input wire logic   rst_n,
    // Filling and draining sides.
    hpm_stream_if.snk  fill,
    hpm_stream_if.src  drain
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    wire           push = fill.valid & fill.ready;
    wire           pop  = drain.valid & drain.ready;

    // Full and empty come straight from the occupancy count.
    assign fill.ready  = (cnt_r != CW'(DEPTH));
    assign drain.valid = (cnt_r != '0);
    assign drain.data  = mem_r[rp_r];

    // Pointers wrap at the depth, so any depth works.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + CW'(push) - CW'(pop);
        end
    end

    // Storage needs no reset; no entry is read before a push.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wp_r] <= fill.data;
        end
    end

endmodule : hpm_buf2

// *** hdl/hpm_pkg.sv ***
package hpm_pkg;

    // Local CPU register map.
    localparam int          ADDR_W        = 16;
    localparam int          DATA_W        = 8;
    localparam int          NCHAN         = 2;
    localparam logic [15:0] ADR_STC       = 16'hffc3;
    localparam logic [15:0] ADR_SYS       = 16'hffc4;
    localparam logic [15:0] ADR_HPC       = 16'hfff0;
    localparam logic [15:0] ADR_IN1       = 16'hfff4;
    localparam logic [15:0] ADR_OUT1      = 16'hfff5;
    localparam logic [15:0] ADR_ST1       = 16'hfff6;
    localparam logic [15:0] ADR_IN2       = 16'hfffc;
    localparam logic [15:0] ADR_OUT2      = 16'hfffd;
    localparam logic [15:0] ADR_ST2       = 16'hfffe;

    // Reset values.
    localparam logic [7:0]  RST_STC       = 8'h00;
    localparam logic [7:0]  RST_SYS       = 8'h09;
    localparam logic [7:0]  RST_HPC       = 8'hf8;
    localparam logic [7:0]  RST_ST        = 8'h00;
    localparam logic [7:0]  RST_BYTE      = 8'h00;
    localparam logic [7:0]  RD_UNMAPPED   = 8'h00;

    // Field positions and masks.
    localparam int          SYS_EN_BIT    = 1;
    localparam logic [7:0]  SYS_RO_MASK   = 8'h08;
    localparam int          STC_PSW_BIT   = 3;
    localparam int          HPC_GATE_BIT  = 0;
    localparam int          HPC_IRQ1_BIT  = 1;
    localparam int          HPC_IRQ2_BIT  = 2;
    localparam logic [7:0]  HPC_FIX_MASK  = 8'hf8;
    localparam int          ST_OBF_BIT    = 0;
    localparam int          ST_IBF_BIT    = 1;
    localparam int          ST_CMD_BIT    = 3;
    localparam logic [7:0]  ST_USER_MASK  = 8'hf4;

    // Write buffer: one command flag above one data byte.
    localparam int          STREAM_W      = 9;
    localparam int          BUF_DEPTH     = 2;

    // Synchroniser vector layout and idle levels.
    localparam int          SYNC_W        = 23;
    localparam int          SY_CS1        = 22;
    localparam int          SY_CS2        = 21;
    localparam int          SY_ACS2       = 20;
    localparam int          SY_HA0        = 19;
    localparam int          SY_RD         = 18;
    localparam int          SY_WR         = 17;
    localparam int          SY_AWR        = 16;
    localparam int          SY_DX         = 8;
    localparam int          SY_DP         = 0;
    localparam logic [22:0] SYNC_RST      = 23'h770000;

endpackage : hpm_pkg

// *** hdl/hpm_stream_if.sv ***
`timescale 1ns/1ps
interface hpm_stream_if #(
    parameter int W = hpm_pkg::STREAM_W
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : hpm_stream_if

// *** hdl/hpm_top.sv ***
// Summary of operation
// - The host port stays inactive unless the port enable bit is set.
// - Two active-low selects pick channel one or channel two.
// - Address line picks status or output byte on reads, command or data on writes.
// - Pin switch bit picks the channel-two select and write strobe pins.
// - Primary bus in single-chip mode, expanded bus otherwise.
// - Input byte captures the host bus at the write strobe's rising edge.
// - Each host input write latches the address line into status bit 3.
// - Output byte drives the bus only while address, select and read strobe are low.
// - Input full sets on host write, clears on local read, is an interrupt.
// - Output full sets on local write, clears on host read.
// - Each input full interrupt reaches the CPU only when enabled.
// - Fast gate drives the gate pin only when control bit 0 is set.
// - Control register bits 7 to 3 are fixed at one.
// - Status bits 3, 1, 0 are read-only; status clears on reset and standby.
// - Status bits 7 to 4 and 2 are local read/write flags.
// - Input byte is local read-only; output byte local read/write.
// - Input full clears on local read start; output full on host read end.
`timescale 1ns/1ps
module hpm_top
    import hpm_pkg::*;
(
    // Clock and reset.
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // Chip mode and low power.
    input  wire logic               expanded_mode,
    input  wire logic               standby,
    // Local CPU register port.
    input  wire logic [ADDR_W-1:0]  cpu_addr,
    input  wire logic [DATA_W-1:0]  cpu_wdata,
    input  wire logic               cpu_wr,
    input  wire logic               cpu_rd,
    output logic      [DATA_W-1:0]  cpu_rdata,
    // Local CPU interrupts, one per channel.
    output logic      [NCHAN-1:0]   cpu_irq,
    // Host control pins.
    input  wire logic               chan_one_select_n,
    input  wire logic               chan_two_select_n,
    input  wire logic               alt_chan_two_select_n,
    input  wire logic               host_cmd_addr_line,
    input  wire logic               host_read_strobe_n,
    input  wire logic               host_write_strobe_n,
    input  wire logic               alt_host_write_strobe_n,
    // Host data bus, single-chip pins.
    input  wire logic [7:0]         host_bus_primary_in,
    output logic      [7:0]         host_bus_primary_out,
    output logic                    host_bus_primary_oe,
    // Host data bus, expanded-mode pins.
    input  wire logic [7:0]         host_bus_expanded_in,
    output logic      [7:0]         host_bus_expanded_out,
    output logic                    host_bus_expanded_oe,
    // Gate output and its software level.
    input  wire logic               sw_gate_level,
    output logic                    addr_gate_out,
    // Host write lost to a full buffer.
    output logic                    host_write_lost
);

    // Register file.
    logic [7:0]         stc_r;
    logic [7:0]         sys_r;
    logic [7:0]         hpc_r;
    logic [7:0]         in_byte_r  [NCHAN];
    logic [7:0]         out_byte_r [NCHAN];
    logic [7:0]         st_r       [NCHAN];
    logic [7:0]         st_nxt     [NCHAN];

    // Host pin synchroniser and sampled strobe state.
    logic [SYNC_W-1:0]  meta_r;
    logic [SYNC_W-1:0]  sync_r;
    logic               wr_prev_r;
    logic [NCHAN-1:0]   wsel_r;
    logic               wcmd_r;
    logic [7:0]         wdat_r;
    logic [NCHAN-1:0]   rdact_r;

    // Output flops.
    logic [7:0]         cpu_rdata_r;
    logic [NCHAN-1:0]   cpu_irq_r;
    logic [7:0]         hbus_r;
    logic               hp_oe_r;
    logic               hx_oe_r;
    logic               gate_hold_r;
    logic               gate_out_r;
    logic               lost_r;

    // Every host pin passes two flops.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= SYNC_RST;
            sync_r <= SYNC_RST;
        end else begin
            meta_r <= {chan_one_select_n, chan_two_select_n, alt_chan_two_select_n,
                       host_cmd_addr_line, host_read_strobe_n, host_write_strobe_n,
                       alt_host_write_strobe_n, host_bus_expanded_in, host_bus_primary_in};
            sync_r <= meta_r;
        end
    end

    // Decoded host pin levels after synchronisation.
    wire       port_en  = sys_r[SYS_EN_BIT];
    wire       psw      = stc_r[STC_PSW_BIT];
    wire       cs1_s    = sync_r[SY_CS1];
    wire       cs2_s    = psw ? sync_r[SY_ACS2] : sync_r[SY_CS2];
    wire       wr_s     = psw ? sync_r[SY_AWR] : sync_r[SY_WR];
    wire       rd_s     = sync_r[SY_RD];
    wire       ha0_s    = sync_r[SY_HA0];
    wire [7:0] hdin_s   = expanded_mode ? sync_r[SY_DX +: 8] : sync_r[SY_DP +: 8];
    wire       sel1     = ~cs1_s & cs2_s;
    wire       sel2     = cs1_s & ~cs2_s;
    wire       chi      = sel2;
    wire       rd_only  = ~rd_s & wr_s;
    wire       wr_only  = ~wr_s & rd_s;
    wire       wr_rise  = ~wr_prev_r & wr_s;
    wire       hrd_act  = port_en & (sel1 | sel2) & rd_only;
    wire [7:0] hrd_data = ha0_s ? st_r[chi] : out_byte_r[chi];

    // Local CPU decode: one hit per register.
    wire       hit_stc  = (cpu_addr == ADR_STC);
    wire       hit_sys  = (cpu_addr == ADR_SYS);
    wire       hit_hpc  = (cpu_addr == ADR_HPC);
    wire [NCHAN-1:0] hit_in  = {cpu_addr == ADR_IN2, cpu_addr == ADR_IN1};
    wire [NCHAN-1:0] hit_out = {cpu_addr == ADR_OUT2, cpu_addr == ADR_OUT1};
    wire [NCHAN-1:0] hit_st  = {cpu_addr == ADR_ST2, cpu_addr == ADR_ST1};
    wire [NCHAN-1:0] irq_en  = {hpc_r[HPC_IRQ2_BIT], hpc_r[HPC_IRQ1_BIT]};
    wire [NCHAN-1:0] fill_rdy;
    wire [NCHAN-1:0] fill_val;

    // Read data mux; the input byte has no local write path.
    wire [7:0] rd_mux = hit_stc    ? stc_r :
                        hit_sys    ? sys_r :
                        hit_hpc    ? hpc_r :
                        hit_in[0]  ? in_byte_r[0] :
                        hit_in[1]  ? in_byte_r[1] :
                        hit_out[0] ? out_byte_r[0] :
                        hit_out[1] ? out_byte_r[1] :
                        hit_st[0]  ? st_r[0] :
                        hit_st[1]  ? st_r[1] : RD_UNMAPPED;

    // Control registers; standby resets sys_r and hpc_r, stc_r keeps its value.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stc_r <= RST_STC;
            sys_r <= RST_SYS;
            hpc_r <= RST_HPC;
        end else if (standby) begin
            sys_r <= RST_SYS;
            hpc_r <= RST_HPC;
        end else if (cpu_wr) begin
            if (hit_stc) begin
                stc_r <= cpu_wdata;
            end
            if (hit_sys) begin
                sys_r <= (cpu_wdata & ~SYS_RO_MASK) | (sys_r & SYS_RO_MASK);
            end
            if (hit_hpc) begin
                hpc_r <= cpu_wdata | HPC_FIX_MASK;
            end
        end
    end

    // Select, address line and data are kept while the write strobe is low.
    // At the rising edge they hold what the host drove.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_r <= 1'b1;
            wsel_r    <= '0;
            wcmd_r    <= 1'b0;
            wdat_r    <= RST_BYTE;
        end else begin
            wr_prev_r <= wr_s;
            if (wr_only) begin
                wsel_r <= {2{port_en}} & {sel2, sel1};
                wcmd_r <= ha0_s;
                wdat_r <= hdin_s;
            end else if (~wr_s) begin
                wsel_r <= '0;
            end
        end
    end

    // Output byte read in progress, per channel.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdact_r <= '0;
        end else begin
            rdact_r <= {2{hrd_act & ~ha0_s}} & {sel2, sel1};
        end
    end

    // Per-channel buffer, data bytes and status.
    genvar ch;
    generate
        for (ch = 0; ch < NCHAN; ch++) begin : g_ch
            hpm_stream_if #(.W(STREAM_W)) fill_if ();
            hpm_stream_if #(.W(STREAM_W)) drain_if ();

            // A local input byte read stalls the drain, so the byte
            // is never replaced under the reader.
            wire loc_rd_in  = cpu_rd & hit_in[ch];
            wire loc_wr_out = cpu_wr & hit_out[ch];
            wire loc_wr_st  = cpu_wr & hit_st[ch];
            wire commit     = drain_if.valid & drain_if.ready;
            wire host_rd_end = rdact_r[ch] & rd_s;

            assign fill_val[ch]   = wr_rise & wsel_r[ch];
            assign fill_if.valid  = fill_val[ch];
            assign fill_if.data   = {wcmd_r, wdat_r};
            assign fill_rdy[ch]   = fill_if.ready;
            assign drain_if.ready = ~loc_rd_in;

            hpm_buf2 #(
                .W     (STREAM_W),
                .DEPTH (BUF_DEPTH)
            ) u_buf (
                .mclk  (mclk),
                .rst_n (rst_n),
                .fill  (fill_if),
                .drain (drain_if)
            );

            // Status next value: a set in the same cycle as a clear wins.
            always_comb begin
                st_nxt[ch] = st_r[ch];
                if (loc_wr_st) begin
                    st_nxt[ch] = (cpu_wdata & ST_USER_MASK) | (st_r[ch] & ~ST_USER_MASK);
                end
                if (commit) begin
                    st_nxt[ch][ST_CMD_BIT] = drain_if.data[8];
                end
                st_nxt[ch][ST_IBF_BIT] = commit | (st_r[ch][ST_IBF_BIT] & ~loc_rd_in);
                st_nxt[ch][ST_OBF_BIT] = loc_wr_out | (st_r[ch][ST_OBF_BIT] & ~host_rd_end);
            end

            // Status clears on reset and in standby.
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    st_r[ch] <= RST_ST;
                end else if (standby) begin
                    st_r[ch] <= RST_ST;
                end else begin
                    st_r[ch] <= st_nxt[ch];
                end
            end

            // Data bytes; reset contents carry no meaning.
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    in_byte_r[ch]  <= RST_BYTE;
                    out_byte_r[ch] <= RST_BYTE;
                end else begin
                    if (commit) begin
                        in_byte_r[ch] <= drain_if.data[7:0];
                    end
                    if (loc_wr_out) begin
                        out_byte_r[ch] <= cpu_wdata;
                    end
                end
            end
        end
    endgenerate

    // One bus is driven, only during a clean read.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hbus_r  <= RST_BYTE;
            hp_oe_r <= 1'b0;
            hx_oe_r <= 1'b0;
        end else begin
            hbus_r  <= hrd_data;
            hp_oe_r <= hrd_act & ~expanded_mode;
            hx_oe_r <= hrd_act & expanded_mode;
        end
    end

    // Local read data, interrupts and lost-write pulse.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata_r <= RST_BYTE;
            cpu_irq_r   <= '0;
            lost_r      <= 1'b0;
        end else begin
            if (cpu_rd) begin
                cpu_rdata_r <= rd_mux;
            end
            cpu_irq_r <= {st_r[1][ST_IBF_BIT], st_r[0][ST_IBF_BIT]} & irq_en;
            lost_r    <= |(fill_val & ~fill_rdy);
        end
    end

    // No fast gate command decoder is built; an enabled
    // fast gate holds the last software level.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gate_hold_r <= 1'b0;
            gate_out_r  <= 1'b0;
        end else begin
            if (!(hpc_r[HPC_GATE_BIT] & port_en)) begin
                gate_hold_r <= sw_gate_level;
            end
            gate_out_r <= (hpc_r[HPC_GATE_BIT] & port_en) ? gate_hold_r : sw_gate_level;
        end
    end

    // Every output comes straight from a flop.
    assign cpu_rdata             = cpu_rdata_r;
    assign cpu_irq               = cpu_irq_r;
    assign host_bus_primary_out  = hbus_r;
    assign host_bus_expanded_out = hbus_r;
    assign host_bus_primary_oe   = hp_oe_r;
    assign host_bus_expanded_oe  = hx_oe_r;
    assign addr_gate_out         = gate_out_r;
    assign host_write_lost       = lost_r;

endmodule : hpm_top

// *** verif/hpm_host_model.sv ***
`timescale 1ns/1ps
module hpm_host_model (
    // Clock.
    input wire logic  mclk,
    // Host control pins.
    output logic      chan_one_select_n,
    output logic      chan_two_select_n,
    output logic      alt_chan_two_select_n,
    output logic      host_cmd_addr_line,
    output logic      host_read_strobe_n,
    output logic      host_write_strobe_n,
    output logic      alt_host_write_strobe_n,
    // Host data and the bus level seen.
    output logic [7:0] host_data,
    input wire logic [7:0] bus_level,
    input wire logic  bus_driven
);
    // Idle host: nothing selected, all three strobes high.
    initial begin
        {chan_one_select_n, chan_two_select_n, alt_chan_two_select_n} = 3'h7;
        {host_read_strobe_n, host_write_strobe_n, alt_host_write_strobe_n} = 3'h7;
        host_cmd_addr_line = 1'b0;
        host_data = 8'h00;
    end

    // One channel selected, channel two on alternate pins if asked.
    task automatic pick(input logic ch2, input logic alt, input logic cmd);
        chan_one_select_n <= ch2;
        chan_two_select_n <= !(ch2 && !alt);
        alt_chan_two_select_n <= !(ch2 && alt);
        host_cmd_addr_line <= cmd;
    endtask : pick

    // Four-cycle phases; data holds through the low phase.
    task automatic host_write(input logic ch2, input logic alt, input logic cmd, input logic [7:0] d);
        @(posedge mclk);
        pick(ch2, alt, cmd);
        host_data <= d;
        if (alt) alt_host_write_strobe_n <= 1'b0; else host_write_strobe_n <= 1'b0;
        repeat (4) @(posedge mclk);
        {host_write_strobe_n, alt_host_write_strobe_n} <= 2'h3;
        repeat (4) @(posedge mclk);
        {chan_one_select_n, chan_two_select_n, alt_chan_two_select_n} <= 3'h7;
        host_data <= ~d;
        @(posedge mclk);
    endtask : host_write

    // Reads sample the bus late in the low phase.
    task automatic host_read(input logic ch2, input logic cmd, output logic [7:0] q, output logic seen);
        @(posedge mclk);
        pick(ch2, 1'b0, cmd);
        host_read_strobe_n <= 1'b0;
        repeat (6) @(posedge mclk);
        q = bus_level;
        seen = bus_driven;
        host_read_strobe_n <= 1'b1;
        repeat (4) @(posedge mclk);
        {chan_one_select_n, chan_two_select_n} <= 2'h3;
        @(posedge mclk);
    endtask : host_read
endmodule : hpm_host_model

// *** verif/hpm_monitor.sv ***
`timescale 1ns/1ps
module hpm_monitor
    import hpm_pkg::*;
(
    // Clock, reset and low power.
    input wire logic              mclk,
    input wire logic              rst_n,
    input wire logic              standby,
    // Local register port.
    input wire logic [ADDR_W-1:0] cpu_addr,
    input wire logic [DATA_W-1:0] cpu_wdata,
    input wire logic              cpu_wr,
    input wire logic              cpu_rd,
    input wire logic [DATA_W-1:0] cpu_rdata,
    input wire logic [NCHAN-1:0]  cpu_irq,
    // Host side pins.
    input wire logic              host_read_strobe_n,
    input wire logic [7:0]        host_bus_primary_out,
    input wire logic              host_bus_primary_oe,
    input wire logic [7:0]        host_bus_expanded_out,
    input wire logic              host_bus_expanded_oe,
    input wire logic              sw_gate_level,
    input wire logic              addr_gate_out
);
    logic sys_en_r;
    logic gate_bit_r;
    // Mirror of the port and fast gate enable bits.
    wire  gate_en  = sys_en_r && gate_bit_r;
    wire  bus_oe   = host_bus_primary_oe || host_bus_expanded_oe;
    // The mirror resets with the design.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sys_en_r   <= 1'b0;
            gate_bit_r <= 1'b0;
        end else begin
            sys_en_r   <= standby ? 1'b0 : (cpu_wr && cpu_addr == ADR_SYS) ? cpu_wdata[SYS_EN_BIT] : sys_en_r;
            gate_bit_r <= standby ? 1'b0 : (cpu_wr && cpu_addr == ADR_HPC) ? cpu_wdata[HPC_GATE_BIT] : gate_bit_r;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Bus pins and drive timing.
    a_bus_same: assert property (host_bus_primary_out == host_bus_expanded_out)
        else $error("bus copies differ");
    a_bus_one: assert property (!(host_bus_primary_oe && host_bus_expanded_oe))
        else $error("both buses driven");
    a_oe_cause: assert property ($rose(bus_oe) |-> $past(host_read_strobe_n, 3) == 1'b0)
        else $error("bus driven without read");
    a_read_idle: assert property (host_read_strobe_n [*5] |-> !bus_oe) else $error("bus driven while idle");
    // Interrupt masking and clearing.
    a_irq_clear: assert property (cpu_rd && cpu_addr == ADR_IN1 |-> ##2 !cpu_irq[0])
        else $error("irq kept after input read");
    a_irq_mask: assert property (cpu_wr && cpu_addr == ADR_HPC && !cpu_wdata[HPC_IRQ2_BIT] |-> ##2 !cpu_irq[1])
        else $error("masked irq raised");
    // Register read values.
    a_unmapped: assert property (cpu_rd && cpu_addr < ADR_STC |=> cpu_rdata == RD_UNMAPPED)
        else $error("unmapped read not zero");
    a_ctl_fixed: assert property (cpu_rd && cpu_addr == ADR_HPC |=> (cpu_rdata & HPC_FIX_MASK) == HPC_FIX_MASK)
        else $error("fixed control bits not one");
    a_stby_clear: assert property (standby && $past(standby) && cpu_rd && cpu_addr == ADR_ST1 |=> cpu_rdata == RST_ST)
        else $error("status not cleared in standby");
    // Gate pin follows software unless held.
    a_gate_soft: assert property (!gate_en |=> addr_gate_out == $past(sw_gate_level))
        else $error("gate not following software");
    a_gate_hold: assert property (gate_en |=> $stable(addr_gate_out)) else $error("gate moved while held");
    c_host_read: cover property ($rose(bus_oe));
    c_irq_one: cover property ($rose(cpu_irq[0]));
    c_gate_held: cover property (gate_en && sw_gate_level != addr_gate_out);
endmodule : hpm_monitor

bind hpm_top hpm_monitor u_hpm_monitor (.*);

// *** verif/test_hpm_top.sv ***
`timescale 1ns/1ps
module test_hpm_top
    import hpm_pkg::*;
;
    logic mclk, rst_n, expanded_mode, standby, cpu_wr, cpu_rd, sw_gate_level;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata, cpu_rdata, pri_out, exp_out, host_data, q;
    logic [1:0]  cpu_irq;
    logic pri_oe, exp_oe, addr_gate_out, seen, lost;
    wire  chan_one_select_n, chan_two_select_n, alt_chan_two_select_n, host_cmd_addr_line;
    wire  host_read_strobe_n, host_write_strobe_n, alt_host_write_strobe_n;
    int   fails = 0;
    int   check_count = 0;
    // A bus shows the device's byte while driven, else the host's.
    wire [7:0] pri_lvl = pri_oe ? pri_out : host_data;
    wire [7:0] exp_lvl = exp_oe ? exp_out : host_data;

    hpm_top u_hpm_top (.*, .host_bus_primary_in(pri_lvl), .host_bus_primary_out(pri_out), .host_bus_primary_oe(pri_oe),
        .host_bus_expanded_in(exp_lvl), .host_bus_expanded_out(exp_out), .host_bus_expanded_oe(exp_oe),
        .host_write_lost(lost));
    hpm_host_model u_hpm_host_model (.*, .bus_level(expanded_mode ? exp_lvl : pri_lvl),
        .bus_driven(expanded_mode ? exp_oe : pri_oe));

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge mclk);
        cpu_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge mclk);
        cpu_rd <= 0;
        @(negedge mclk);
        chk(cpu_rdata, exp);
    endtask : rd
    task automatic irq_is(input logic [1:0] exp);
        repeat (3) @(negedge mclk);
        chk({6'h00, cpu_irq}, {6'h00, exp});
    endtask : irq_is

    // Reset values, fixed bits, port enable.
    task automatic t_regs();
        rd(ADR_STC, RST_STC);
        rd(ADR_HPC, RST_HPC);
        rd(ADR_ST2, RST_ST);
        rd(16'hff00, RD_UNMAPPED);
        wr(ADR_HPC, 8'h00);
        rd(ADR_HPC, RST_HPC);
        wr(ADR_ST1, 8'hff);
        rd(ADR_ST1, ST_USER_MASK);
        wr(ADR_ST1, 8'h00);
        u_hpm_host_model.host_write(1'b0, 1'b0, 1'b1, 8'h11);
        rd(ADR_ST1, 8'h00);
        wr(ADR_SYS, 8'h02);
        rd(ADR_SYS, 8'h0a);
        $display("t_regs done");
    endtask : t_regs
    // Command then data write on channel one.
    task automatic t_write();
        wr(ADR_HPC, 8'h02);
        u_hpm_host_model.host_write(1'b0, 1'b0, 1'b1, 8'ha5);
        rd(ADR_ST1, 8'h0a);
        irq_is(2'b01);
        rd(ADR_IN1, 8'ha5);
        irq_is(2'b00);
        rd(ADR_ST1, 8'h08);
        wr(ADR_IN1, 8'h55);
        u_hpm_host_model.host_write(1'b0, 1'b0, 1'b0, 8'h5a);
        rd(ADR_IN1, 8'h5a);
        rd(ADR_ST1, 8'h00);
        chk({7'h00, lost}, 8'h00);
        $display("t_write done");
    endtask : t_write
    // Channel two on alternate pins; primary pins ignored.
    task automatic t_alt();
        wr(ADR_HPC, 8'h00);
        wr(ADR_STC, 8'h08);
        u_hpm_host_model.host_write(1'b1, 1'b1, 1'b1, 8'hc3);
        irq_is(2'b00);
        wr(ADR_HPC, 8'h04);
        irq_is(2'b10);
        rd(ADR_ST2, 8'h0a);
        rd(ADR_IN2, 8'hc3);
        u_hpm_host_model.host_write(1'b1, 1'b0, 1'b0, 8'h3c);
        rd(ADR_IN2, 8'hc3);
        wr(ADR_STC, 8'h00);
        wr(ADR_HPC, 8'h00);
        $display("t_alt done");
    endtask : t_alt
    // Output byte handshake and the expanded bus.
    task automatic t_out();
        wr(ADR_OUT1, 8'h3c);
        rd(ADR_ST1, 8'h01);
        u_hpm_host_model.host_read(1'b0, 1'b1, q, seen);
        chk(q, 8'h01);
        u_hpm_host_model.host_read(1'b0, 1'b0, q, seen);
        chk(q, 8'h3c);
        chk({7'h00, seen}, 8'h01);
        rd(ADR_ST1, 8'h00);
        expanded_mode <= 1'b1;
        wr(ADR_OUT2, 8'h69);
        u_hpm_host_model.host_read(1'b1, 1'b0, q, seen);
        chk(q, 8'h69);
        expanded_mode <= 1'b0;
        $display("t_out done");
    endtask : t_out
    // Gate follows software, then holds under the fast gate.
    task automatic t_gate();
        sw_gate_level <= 1'b1;
        irq_is(2'b00);
        chk({7'h00, addr_gate_out}, 8'h01);
        wr(ADR_HPC, 8'h01);
        sw_gate_level <= 1'b0;
        irq_is(2'b00);
        chk({7'h00, addr_gate_out}, 8'h01);
        wr(ADR_HPC, 8'h00);
        irq_is(2'b00);
        chk({7'h00, addr_gate_out}, 8'h00);
        $display("t_gate done");
    endtask : t_gate
    // Standby restores sys_r, hpc_r and the status registers.
    task automatic t_standby();
        wr(ADR_HPC, 8'h06);
        wr(ADR_ST1, 8'hf4);
        standby <= 1'b1;
        rd(ADR_ST1, RST_ST);
        rd(ADR_HPC, RST_HPC);
        rd(ADR_SYS, RST_SYS);
        standby <= 1'b0;
        $display("t_standby done");
    endtask : t_standby

    // Clock at 25 MHz.
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Reset three cycles, settle, run the tests.
    initial begin
        {rst_n, expanded_mode, standby, cpu_wr, cpu_rd, sw_gate_level} = 6'h00;
        cpu_addr = ADR_STC;
        cpu_wdata = 8'h00;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        t_regs();
        t_write();
        t_alt();
        t_out();
        t_gate();
        t_standby();
        conclude();
    end
    // Watchdog, far beyond the test length.
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        conclude();
    end
endmodule : test_hpm_top
